// ==== rtl/dsmd_detector.sv ====
/*
  DIFFSENS mode detector: classifies the comparator outputs, debounces the
  mode, sequences driver enables from power-up and keeps an APB register file.
  Assumes comparator inputs are already synchronous to pclk and that presetn
  is a power-good reset.
*/
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module dsmd_detector
  import dsmd_pkg::*;
#(
  parameter longint unsigned SETTLE_CYC = DSMD_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] diffsens_cmp,
  output logic drv_hiz,
  output logic se_en,
  output logic lvd_en,
  output logic gnd_drv_en,
  output logic term_se,
  output logic term_lvd,
  output logic diffsens_drv_en,
  output logic [1:0] bus_mode,
  output logic irq
);

  localparam int CW = 32;

  dsmd_mode_t raw_mode;
  dsmd_mode_t cand_reg;
  dsmd_mode_t active_reg;
  dsmd_state_t state_reg;
  logic [CW-1:0] cnt_reg;
  logic cnt_done;
  logic [1:0] ctrl_reg;
  logic [DSMD_EV_N-1:0] ev_stat_reg;
  logic [DSMD_EV_N-1:0] ev_mask_reg;
  logic [DSMD_EV_N-1:0] ev_set;
  logic ready_reg;
  dsmd_ctrl_t ctrl_next;
  logic apb_access;
  logic apb_rd_stat;

  // Band classification; the gap between LVD and HVD maps to indeterminate
  always_comb begin
    if (diffsens_cmp[DSMD_CMP_HVD]) begin
      raw_mode = DSMD_MODE_HVD;
    end else if (diffsens_cmp[DSMD_CMP_LVD_HI]) begin
      raw_mode = DSMD_MODE_IND;
    end else if (diffsens_cmp[DSMD_CMP_LVD_LO]) begin
      raw_mode = DSMD_MODE_LVD;
    end else begin
      raw_mode = DSMD_MODE_SE;
    end
  end

  assign cnt_done = (cnt_reg >= CW'(SETTLE_CYC - 1));

  // Candidate mode tracks the raw class
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cand_reg <= DSMD_MODE_IND;
    end else begin
      cand_reg <= raw_mode;
    end
  end

  // Interval counter; in power-up it counts free, elsewhere it restarts on any change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (state_reg == DSMD_ST_POWERUP) begin
      cnt_reg <= cnt_done ? '0 : cnt_reg + CW'(1);
    end else if (raw_mode != cand_reg || raw_mode == DSMD_MODE_IND || raw_mode == active_reg) begin
      cnt_reg <= '0;
    end else if (!cnt_done) begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= DSMD_ST_POWERUP;
      active_reg <= DSMD_MODE_IND;
      ready_reg <= 1'b0;
    end else begin
      case (state_reg)
        DSMD_ST_POWERUP: begin
          if (cnt_done) begin
            state_reg <= DSMD_ST_STABILIZE;
          end
        end
        DSMD_ST_STABILIZE: begin
          if (cnt_done && cand_reg == raw_mode && raw_mode != DSMD_MODE_IND) begin
            active_reg <= raw_mode;
            ready_reg <= 1'b1;
            state_reg <= DSMD_ST_RUN;
          end
        end
        DSMD_ST_RUN: begin
          // The counter still reads done on the first cycle here, so the new mode must differ
          if (cnt_done && cand_reg == raw_mode && raw_mode != DSMD_MODE_IND && raw_mode != active_reg) begin
            state_reg <= DSMD_ST_SWITCH;
          end
        end
        DSMD_ST_SWITCH: begin
          active_reg <= cand_reg;
          state_reg <= DSMD_ST_RUN;
        end
        default: begin
          state_reg <= DSMD_ST_POWERUP;
        end
      endcase
    end
  end

  // Driver and termination controls from the active mode
  always_comb begin
    ctrl_next = '0;
    ctrl_next.drv_hiz = 1'b1;
    if (ready_reg) begin
      case (active_reg)
        DSMD_MODE_SE: begin
          ctrl_next.drv_hiz = 1'b0;
          ctrl_next.se_en = 1'b1;
          ctrl_next.gnd_drv_en = 1'b1;
          ctrl_next.term_se = ctrl_reg[DSMD_CTRL_TERM_EN];
        end
        DSMD_MODE_LVD: begin
          ctrl_next.drv_hiz = 1'b0;
          ctrl_next.lvd_en = 1'b1;
          ctrl_next.term_lvd = ctrl_reg[DSMD_CTRL_TERM_EN];
        end
        DSMD_MODE_HVD: begin
          ctrl_next.drv_hiz = 1'b1;
        end
        default: begin
          ctrl_next.drv_hiz = 1'b1;
        end
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_hiz <= 1'b1;
      se_en <= 1'b0;
      lvd_en <= 1'b0;
      gnd_drv_en <= 1'b0;
      term_se <= 1'b0;
      term_lvd <= 1'b0;
      diffsens_drv_en <= 1'b0;
      bus_mode <= DSMD_MODE_IND;
    end else begin
      drv_hiz <= ctrl_next.drv_hiz;
      se_en <= ctrl_next.se_en;
      lvd_en <= ctrl_next.lvd_en;
      gnd_drv_en <= ctrl_next.gnd_drv_en;
      term_se <= ctrl_next.term_se;
      term_lvd <= ctrl_next.term_lvd;
      // Sourcing continues in every mode; the line is still monitored meanwhile
      diffsens_drv_en <= ctrl_reg[DSMD_CTRL_TERM_EN] & ctrl_reg[DSMD_CTRL_DIFFSENS_DRV];
      bus_mode <= active_reg;
    end
  end

  // APB: zero wait states
  assign apb_access = psel & penable;
  assign apb_rd_stat = apb_access & ~pwrite & (paddr == DSMD_OFF_IRQ_STAT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= DSMD_CTRL_RST;
      ev_mask_reg <= DSMD_MASK_RST;
    end else if (apb_access && pwrite) begin
      if (paddr == DSMD_OFF_CTRL) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (paddr == DSMD_OFF_IRQ_MASK) begin
        ev_mask_reg <= pwdata[DSMD_EV_N-1:0];
      end
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[DSMD_EV_MODE_CHG] = (state_reg == DSMD_ST_SWITCH);
    ev_set[DSMD_EV_READY] = (state_reg == DSMD_ST_STABILIZE) && cnt_done && cand_reg == raw_mode &&
                            raw_mode != DSMD_MODE_IND;
    ev_set[DSMD_EV_HVD] = (state_reg == DSMD_ST_SWITCH) && (cand_reg == DSMD_MODE_HVD);
  end

  // Read clears; an event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_stat_reg <= '0;
    end else begin
      ev_stat_reg <= (apb_rd_stat ? '0 : ev_stat_reg) | ev_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((apb_rd_stat ? '0 : ev_stat_reg) | ev_set) & ev_mask_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        case (paddr)
          DSMD_OFF_CTRL: prdata <= {30'h0, ctrl_reg};
          DSMD_OFF_STATUS: prdata <= {20'h0, state_reg, 3'h0, ready_reg, cand_reg, active_reg};
          // Events landing now are reported, since the access edge clears them
          DSMD_OFF_IRQ_STAT: prdata <= {29'h0, ev_stat_reg | ev_set};
          DSMD_OFF_IRQ_MASK: prdata <= {29'h0, ev_mask_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

// ==== rtl/dsmd_pkg.sv ====
/*
  Package for the DIFFSENS mode detector: mode encodings, comparator layout,
  register map, field positions and timing counts.
  Assumes a 250 MHz pclk and an APB master with 32-bit data.
*/
package dsmd_pkg;
  // Clock period in ps and the settle interval in ms
  localparam int unsigned DSMD_CLK_PS = 4000;
  localparam int unsigned DSMD_SETTLE_MS = 100;
  localparam longint unsigned DSMD_SETTLE_CYC = (longint'(DSMD_SETTLE_MS) * 64'd1000000000) / DSMD_CLK_PS;

  // Comparator thresholds in mV, for reference only; the analog side does the compare
  localparam int unsigned DSMD_THR_LVD_LO_MV = 700;
  localparam int unsigned DSMD_THR_LVD_HI_MV = 1900;
  localparam int unsigned DSMD_THR_HVD_MV = 2400;

  // Comparator inputs: [0] vin >= 0,7V, [1] vin > 1,9V, [2] vin >= 2,4V
  localparam int DSMD_CMP_LVD_LO = 0;
  localparam int DSMD_CMP_LVD_HI = 1;
  localparam int DSMD_CMP_HVD = 2;

  typedef enum logic [1:0] {
    DSMD_MODE_SE = 2'h0,
    DSMD_MODE_LVD = 2'h1,
    DSMD_MODE_HVD = 2'h2,
    DSMD_MODE_IND = 2'h3
  } dsmd_mode_t;

  typedef enum logic [3:0] {
    DSMD_ST_POWERUP = 4'h1,
    DSMD_ST_STABILIZE = 4'h2,
    DSMD_ST_RUN = 4'h4,
    DSMD_ST_SWITCH = 4'h8
  } dsmd_state_t;

  // Driver side controls as one bundle
  typedef struct packed {
    logic drv_hiz;
    logic se_en;
    logic lvd_en;
    logic gnd_drv_en;
    logic term_se;
    logic term_lvd;
  } dsmd_ctrl_t;

  // Register offsets
  localparam logic [11:0] DSMD_OFF_CTRL = 12'h000;
  localparam logic [11:0] DSMD_OFF_STATUS = 12'h004;
  localparam logic [11:0] DSMD_OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] DSMD_OFF_IRQ_MASK = 12'h00C;

  // CTRL fields
  localparam int DSMD_CTRL_TERM_EN = 0;
  localparam int DSMD_CTRL_DIFFSENS_DRV = 1;
  localparam logic [1:0] DSMD_CTRL_RST = 2'h3;

  // STATUS fields
  localparam int DSMD_ST_ACTIVE_LSB = 0;
  localparam int DSMD_ST_RAW_LSB = 2;
  localparam int DSMD_ST_READY = 4;
  localparam int DSMD_ST_FSM_LSB = 8;

  // Interrupt events
  localparam int DSMD_EV_MODE_CHG = 0;
  localparam int DSMD_EV_READY = 1;
  localparam int DSMD_EV_HVD = 2;
  localparam int DSMD_EV_N = 3;
  localparam logic [DSMD_EV_N-1:0] DSMD_MASK_RST = 3'h0;
endpackage

// ==== test/diffsens_mode_detector_tb.sv ====
/* Bench for dsmd_detector: APB tasks, mode scenarios and verdict.
   Uses dsmd_bus_model for DIFFSENS and a short settle count. */
`timescale 1ns/1ps
module diffsens_mode_detector_tb;
  import dsmd_pkg::*;
  localparam longint unsigned SETTLE_CYC = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic drv_hiz, se_en, lvd_en, gnd_drv_en, term_se, term_lvd, diffsens_drv_en, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] diffsens_cmp;
  logic [1:0] bus_mode;
  dsmd_mode_t mode = DSMD_MODE_LVD;
  int mismatches = 0, tests_run = 0, cyc = 0, n;
  dsmd_bus_model u_bus (.mode(mode), .diffsens_cmp(diffsens_cmp));
  dsmd_detector #(.SETTLE_CYC(SETTLE_CYC)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .diffsens_cmp, .drv_hiz, .se_en, .lvd_en, .gnd_drv_en, .term_se, .term_lvd,
    .diffsens_drv_en, .bus_mode, .irq);
  initial forever #2 pclk = ~pclk;
  always @(posedge pclk) if (presetn) cyc <= cyc + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wait_mode(input logic [1:0] m);
    n = 0;
    while (bus_mode !== m && n < 200) begin
      @(posedge pclk);
      n++;
    end
    check(bus_mode, m);
    repeat (3) @(posedge pclk);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic test_reset();
    repeat (8) @(posedge pclk);
    check({drv_hiz, bus_mode}, 3'h7);
    presetn <= 1;
    @(posedge pclk);
    apb(0, DSMD_OFF_CTRL, 0);
    check(rd, 32'h3);
    check(diffsens_drv_en, 1);
    apb(1, DSMD_OFF_CTRL, 32'h1);
    apb(0, DSMD_OFF_CTRL, 0);
    check(rd, 32'h1);
    check(diffsens_drv_en, 0);
    apb(1, DSMD_OFF_CTRL, 32'h3);
    apb(0, DSMD_OFF_IRQ_MASK, 0);
    check(rd, 32'h0);
    apb(1, 12'h010, 32'hF);
    check(err, 1);
    check(rd, 32'h0);
    check(drv_hiz, 1);
    $display("reset test done");
  endtask
  task automatic test_powerup();
    wait_mode(2'h1);
    check(cyc >= 2 * SETTLE_CYC, 1);
    check({drv_hiz, se_en, lvd_en, gnd_drv_en, term_se, term_lvd}, 6'h09);
    apb(0, DSMD_OFF_STATUS, 0);
    check(rd, 32'h415);
    $display("power-up test done");
  endtask
  task automatic test_glitch();
    mode <= DSMD_MODE_IND;
    repeat (2 * SETTLE_CYC) @(posedge pclk);
    check(bus_mode, 2'h1);
    mode <= DSMD_MODE_SE;
    repeat (SETTLE_CYC - 1) @(posedge pclk);
    mode <= DSMD_MODE_LVD;
    repeat (2 * SETTLE_CYC) @(posedge pclk);
    check({bus_mode, lvd_en}, 3'h3);
    apb(0, DSMD_OFF_IRQ_STAT, 0);
    check(rd, 32'h2);
    $display("glitch test done");
  endtask
  task automatic test_se_irq();
    apb(1, DSMD_OFF_IRQ_MASK, 32'h1);
    mode <= DSMD_MODE_SE;
    wait_mode(2'h0);
    check(n >= SETTLE_CYC, 1);
    check({gnd_drv_en, se_en, term_se, lvd_en, irq}, 5'h1D);
    apb(0, DSMD_OFF_IRQ_STAT, 0);
    check(rd, 32'h1);
    repeat (2) @(posedge pclk);
    check(irq, 0);
    apb(1, DSMD_OFF_IRQ_MASK, 0);
    $display("SE and interrupt test done");
  endtask
  task automatic test_hvd();
    mode <= DSMD_MODE_HVD;
    wait_mode(2'h2);
    check({drv_hiz, se_en, lvd_en, gnd_drv_en}, 4'h8);
    check(irq, 0);
    apb(0, DSMD_OFF_IRQ_STAT, 0);
    check(rd, 32'h5);
    $display("HVD test done");
  endtask
  initial begin
    test_reset();
    test_powerup();
    test_glitch();
    test_se_irq();
    test_hvd();
    complete_run();
  end
  initial begin
    #40000;
    mismatches++;
    complete_run();
  end
endmodule
bind dsmd_detector dsmd_monitor #(.SETTLE_CYC(SETTLE_CYC)) u_mon (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .drv_hiz, .se_en, .lvd_en, .gnd_drv_en, .term_se, .term_lvd, .diffsens_cmp, .bus_mode);

// ==== test/dsmd_bus_model.sv ====
/* Bus side model: turns the mode the bench asks for into comparator levels.
   Assumes the bench changes mode right after a rising edge. */
`timescale 1ns/1ps
module dsmd_bus_model
  import dsmd_pkg::*;
(
  input wire dsmd_mode_t mode,
  output logic [2:0] diffsens_cmp
);
  // Indeterminate is modelled in the upper gap, which the lower and middle comparators both see
  always_comb begin
    case (mode)
      DSMD_MODE_SE: diffsens_cmp = 3'h0;
      DSMD_MODE_LVD: diffsens_cmp = 3'h1;
      DSMD_MODE_HVD: diffsens_cmp = 3'h7;
      default: diffsens_cmp = 3'h3;
    endcase
  end
endmodule

// ==== test/dsmd_monitor.sv ====
/* Checker for dsmd_detector port behaviour.
   Bound from the bench top file; SETTLE_CYC must match the instance. */
`timescale 1ns/1ps
module dsmd_monitor #(
  parameter longint unsigned SETTLE_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic drv_hiz,
  input wire logic se_en,
  input wire logic lvd_en,
  input wire logic gnd_drv_en,
  input wire logic term_se,
  input wire logic term_lvd,
  input wire logic [2:0] diffsens_cmp,
  input wire logic [1:0] bus_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Floor spans both intervals, since the mode must also settle after power-up
  longint unsigned up_cnt, run_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt <= 0;
      run_cnt <= 0;
    end else begin
      up_cnt <= (up_cnt < 2 * SETTLE_CYC) ? up_cnt + 1 : up_cnt;
      run_cnt <= (diffsens_cmp == $past(diffsens_cmp)) ? run_cnt + 1 : 0;
    end
  end
  chk_hiz_powerup: assert property (up_cnt < 2 * SETTLE_CYC |-> drv_hiz)
    else $error("drivers left high impedance early");
  chk_mode_debounce: assert property ($changed(bus_mode) |->
    bus_mode != 2'h3 && $past(run_cnt, 2) >= SETTLE_CYC)
    else $error("mode changed without a full settle interval");
  chk_hvd_hiz: assert property (bus_mode == 2'h2 |-> drv_hiz && !se_en && !lvd_en && !gnd_drv_en)
    else $error("drivers active in HVD mode");
  chk_gnd_only_se: assert property (gnd_drv_en |-> bus_mode == 2'h0)
    else $error("ground driver on outside SE");
  chk_gnd_held_se: assert property (bus_mode == 2'h0 |-> gnd_drv_en)
    else $error("ground driver off in SE");
  chk_term_follows: assert property (term_lvd |-> bus_mode == 2'h1)
    else $error("LVD termination outside LVD");
  chk_term_se_only: assert property (term_se |-> bus_mode == 2'h0)
    else $error("SE termination outside SE");
  chk_lvd_mode: assert property (lvd_en |-> !drv_hiz && bus_mode == 2'h1)
    else $error("LVD drivers outside LVD");
  chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("APB answer not in access cycle");
  chk_apb_err: assert property (pslverr |-> pready)
    else $error("error without ready");
  cover property (bus_mode == 2'h1 && !drv_hiz);
  cover property (gnd_drv_en);
  cover property (bus_mode == 2'h2 && drv_hiz);
endmodule
